// [dv/cseac_adc_model.sv]
`timescale 1ns/10ps
module cseac_adc_model (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic adc_convert,
  input wire logic [2:0] adc_channel,
  input wire logic slow,
  input wire logic [15:0] base,
  output logic adc_data_valid,
  output logic [15:0] adc_data
);
  logic [2:0] cnt_reg;
  logic [15:0] last_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 3'h0;
      adc_data_valid <= 1'h0;
      adc_data <= 16'h0;
      last_reg <= 16'h0;
    end else begin
      adc_data_valid <= 1'h0;
      // Stale data is inverted so a sequencer that samples late sees garbage.
      adc_data <= ~last_reg;
      if (adc_convert) begin
        cnt_reg <= slow ? 3'h4 : 3'h1;
      end else if (cnt_reg == 3'h1) begin
        adc_data_valid <= 1'h1;
        adc_data <= base + 16'(adc_channel);
        last_reg <= base + 16'(adc_channel);
        cnt_reg <= 3'h0;
      end else if (cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
    end
  end
endmodule

// [dv/cseac_chk.sv]
`timescale 1ns/10ps
module cseac_chk
  import cseac_pkg::*;
#(
  parameter int ALERT_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire cseac_sense_t sense,
  input wire logic adc_convert,
  input wire cseac_pins_t pins,
  input wire logic host_alert_n,
  input wire logic reverse_active,
  input wire logic reverse_cutback,
  input wire logic charger_run
);
  // Counting low cycles avoids a long unrolled repetition for the pulse width.
  int lo_cnt;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= host_alert_n ? 0 : lo_cnt + 1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_wait: assert property (s_req |=> s_ans)
    else $error("bus answer not in one cycle");
  chk_convert_pulse: assert property (adc_convert |=> !adc_convert)
    else $error("convert pulse too long");
  chk_rev_qualify: assert property (reverse_active |->
    $past(sense.batt_above_3v && sense.drv_supply_ok && sense.therm_in_rev_range))
    else $error("reverse without qualification");
  chk_rev_cutback: assert property (reverse_cutback |->
    $past(sense.rev_discharge_over)) else $error("cutback without overcurrent");
  chk_state_rev_off: assert property (reverse_active |->
    !pins.charge_state_pin_a_oe && !pins.charge_state_pin_b_oe)
    else $error("state pins on in reverse");
  chk_input_fault_stop: assert property ($past(sense.over_pin_tripped ||
    sense.input_above_int_ov || !sense.input_above_ok || !sense.under_pin_ok)
    |-> !charger_run) else $error("charging during input fault");
  chk_inhibit_stop: assert property ($past(sense.charge_inhibit) |-> !charger_run)
    else $error("charging while inhibited");
  chk_alert_width: assert property ($rose(host_alert_n) |-> lo_cnt == ALERT_CYCLES)
    else $error("alert pulse width wrong");
  chk_alert_bound: assert property (!host_alert_n |-> lo_cnt < ALERT_CYCLES)
    else $error("alert pulse too long");
endmodule
bind cseac_top cseac_chk #(.ALERT_CYCLES(ALERT_CYCLES)) u_chk (.*);

// [dv/tb_top.sv]
`timescale 1ns/10ps
`include "cseac_consts.svh"
module tb_top
  import cseac_pkg::*;
;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic slow = 1'h0;
  logic vld, cnv, alert_n, rev, cut, run, wait_r;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, q, r;
  logic [15:0] adat;
  logic [15:0] base = 16'h0;
  logic [15:0] res_m [8];
  logic [2:0] ch;
  cseac_sense_t sense;
  cseac_pins_t pins;
  int fail_count = 0;
  int num_checks = 0;
  cseac_top #(.ALERT_CYCLES(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wait_r), .sense(sense), .adc_data_valid(vld),
    .adc_data(adat), .adc_convert(cnv), .adc_channel(ch), .pins(pins),
    .host_alert_n(alert_n), .reverse_active(rev), .reverse_cutback(cut), .charger_run(run));
  cseac_adc_model u_adc (.clk_sys(clk_sys), .arst_n(arst_n), .adc_convert(cnv),
    .adc_channel(ch), .slow(slow), .base(base), .adc_data_valid(vld), .adc_data(adat));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do begin
      @(posedge clk_sys);
    end while (wait_r !== 1'h0);
    q = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  task automatic reg_rd(logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic set_fault(int i);
    sense.over_pin_tripped <= (i == 0);
    sense.input_above_int_ov <= (i == 1);
    sense.input_above_ok <= (i != 2);
    sense.under_pin_ok <= (i != 3);
    sense.high_impedance_state <= (i == 4);
  endtask
  function automatic logic [1:0] st_exp(logic [1:0] c);
    return (c == 2'h0) ? 2'h2 : (c == 2'h1) ? 2'h1 : (c == 2'h2) ? 2'h3 : 2'h0;
  endfunction
  function automatic logic [1:0] uvov(int i);
    return (i < 2) ? 2'h1 : (i < 4) ? 2'h2 : 2'h0;
  endfunction
  task automatic poll_adc();
    int n;
    n = 0;
    do begin
      reg_rd(`CSEAC_ADDR_CTRL);
      n++;
    end while (q[1] !== 1'h0 && n < 60);
  endtask
  task automatic adc_run(logic [7:0] dis);
    reg_wr(`CSEAC_ADDR_ADC_DIS, {24'h0, dis});
    base <= 16'($urandom);
    reg_wr(`CSEAC_ADDR_CTRL, 32'h00E);
    poll_adc();
    chk("adc_en", q[1], 32'h0);
    for (int c = 0; c < 8; c++) begin
      if (!dis[c]) res_m[c] = base + 16'(c);
      reg_rd(`CSEAC_ADDR_RESULT + 8'(4 * c));
      chk("result", q, {16'h0, res_m[c]});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    tick(20000);
    fail_count++;
    stop_test();
  end
  initial begin
    sense = '0;
    sense.input_above_ok = 1'h1;
    sense.under_pin_ok = 1'h1;
    for (int c = 0; c < 8; c++) res_m[c] = 16'h0;
    void'($urandom(76520));
    tick(5);
    arst_n <= 1'h1;
    tick(3);
    reg_rd(`CSEAC_ADDR_CTRL);
    chk("ctrl", q, `CSEAC_CTRL_RESET);
    reg_rd(`CSEAC_ADDR_MASK);
    chk("mask", q, `CSEAC_MASK_RESET);
    reg_rd(`CSEAC_ADDR_RESULT);
    chk("result0", q, 32'h0);
    reg_rd(8'h14);
    chk("unmapped", q, 32'h0);
    reg_wr(`CSEAC_ADDR_STATUS, 32'hFFFFFFFF);
    reg_rd(`CSEAC_ADDR_STATUS);
    chk("status", q, 32'h1);
    reg_rd(`CSEAC_ADDR_FLAG);
    chk("flag", q, 32'h1);
    reg_rd(`CSEAC_ADDR_FLAG);
    chk("flag", q, 32'h0);
    chk("pins", pins, 32'h6);
    chk("run", run, 32'h1);
    for (int c = 0; c < 5; c++) begin
      sense.charge_state_code <= c[1:0];
      tick(3);
      chk("state", pins[1:0], st_exp(c[1:0]));
    end
    sense.charge_inhibit <= 1'h1;
    tick(3);
    chk("inhibit", pins[1:0], 32'h0);
    sense.charge_inhibit <= 1'h0;
    repeat (4) begin
      r = $urandom;
      reg_wr(`CSEAC_ADDR_CTRL, 32'h038 | (r & 32'h1C0));
      tick(2);
      chk("forced", pins, {r[8], r[6], r[7]});
    end
    reg_wr(`CSEAC_ADDR_CTRL, 32'h008);
    tick(20);
    reg_rd(`CSEAC_ADDR_FLAG);
    for (int i = 0; i < 5; i++) begin
      set_fault(i);
      for (int n = 0; n < 12 && alert_n !== 1'h0; n++) tick(1);
      chk("alert", alert_n, 32'h0);
      tick(2);
      chk("pg", pins[2], 32'h0);
      if (i < 4) chk("run", run, 32'h0);
      reg_rd(`CSEAC_ADDR_STATUS);
      chk("ovuv", q[10:9], uvov(i));
      set_fault(5);
      tick(20);
      chk("resume", run, 32'h1);
      reg_rd(`CSEAC_ADDR_FLAG);
      chk("ovuv flag", q[10:9], uvov(i));
    end
    reg_wr(`CSEAC_ADDR_MASK, 32'h1FFF);
    set_fault(0);
    repeat (10) begin
      tick(1);
      chk("masked", alert_n, 32'h1);
    end
    reg_rd(`CSEAC_ADDR_FLAG);
    chk("masked flag", q[9], 32'h1);
    set_fault(5);
    tick(4);
    reg_wr(`CSEAC_ADDR_MASK, 32'h0);
    reg_wr(`CSEAC_ADDR_CTRL, 32'h009);
    for (int k = 0; k < 7; k++) begin
      r = (k < 6) ? $urandom : 32'h7;
      sense.batt_above_3v <= r[0];
      sense.drv_supply_ok <= r[1];
      sense.therm_in_rev_range <= r[2];
      tick(3);
      chk("rev", rev, &r[2:0]);
    end
    reg_rd(`CSEAC_ADDR_STATUS);
    chk("rev status", q[11], 32'h1);
    sense.rev_discharge_over <= 1'h1;
    tick(3);
    chk("cutback", cut, 32'h1);
    sense.rev_discharge_over <= 1'h0;
    reg_wr(`CSEAC_ADDR_CTRL, 32'h008);
    tick(2);
    chk("rev off", rev, 32'h0);
    slow <= 1'($urandom);
    adc_run(8'h00);
    reg_rd(`CSEAC_ADDR_STATUS);
    chk("done", q[12], 32'h1);
    adc_run(8'($urandom) & 8'h7F);
    adc_run(8'hFF);
    reg_rd(`CSEAC_ADDR_FLAG);
    chk("done flag", q[12], 32'h1);
    reg_wr(`CSEAC_ADDR_ADC_DIS, 32'h0);
    reg_wr(`CSEAC_ADDR_CTRL, 32'h00A);
    tick(30);
    reg_rd(`CSEAC_ADDR_STATUS);
    chk("done cont", q[12], 32'h0);
    reg_rd(`CSEAC_ADDR_FLAG);
    chk("done flag cont", q[12], 32'h0);
    reg_wr(`CSEAC_ADDR_CTRL, 32'h008);
    tick(1);
    repeat (20) begin
      tick(1);
      chk("halt", cnv, 32'h0);
    end
    reg_wr(`CSEAC_ADDR_CTRL, 32'h00A);
    tick(10);
    base <= 16'($urandom);
    reg_wr(`CSEAC_ADDR_CTRL, 32'h00E);
    poll_adc();
    chk("to oneshot", q[1], 32'h0);
    reg_rd(`CSEAC_ADDR_RESULT + 8'h1C);
    chk("last channel", q, {16'h0, base + 16'h7});
    stop_test();
  end
endmodule

// [logic/cseac_consts.svh]
`ifndef CSEAC_CONSTS_SVH
`define CSEAC_CONSTS_SVH

// Register byte addresses.
`define CSEAC_ADDR_CTRL 8'h00
`define CSEAC_ADDR_ADC_DIS 8'h04
`define CSEAC_ADDR_STATUS 8'h08
`define CSEAC_ADDR_FLAG 8'h0C
`define CSEAC_ADDR_MASK 8'h10
`define CSEAC_ADDR_RESULT 8'h20

// Control register fields.
`define CSEAC_CTRL_REV_EN 0
`define CSEAC_CTRL_ADC_EN 1
`define CSEAC_CTRL_ONESHOT 2
`define CSEAC_CTRL_CHG_EN 3
`define CSEAC_CTRL_PG_DIS 4
`define CSEAC_CTRL_STATE_DIS 5
`define CSEAC_CTRL_FORCE_A 6
`define CSEAC_CTRL_FORCE_B 7
`define CSEAC_CTRL_FORCE_C 8
`define CSEAC_CTRL_W 9
`define CSEAC_CTRL_RESET 9'h008

// Status, flag and mask bit positions.
`define CSEAC_ST_PG 0
`define CSEAC_ST_IN_CUR_REG 1
`define CSEAC_ST_IN_VOLT_REG 2
`define CSEAC_ST_WATCHDOG 3
`define CSEAC_ST_CHG_CHANGE 4
`define CSEAC_ST_TS_CHANGE 5
`define CSEAC_ST_THERMAL_SHUTDOWN 6
`define CSEAC_ST_BAT_OV 7
`define CSEAC_ST_SAFETY 8
`define CSEAC_ST_IN_OV 9
`define CSEAC_ST_IN_UV 10
`define CSEAC_ST_REVERSE 11
`define CSEAC_ST_ADC_DONE 12
`define CSEAC_NSRC 13
`define CSEAC_MASK_RESET 13'h0000

// Alert pulse timing.
`define CSEAC_ALERT_US 256
`define CSEAC_CLK_MHZ 20

`endif

// [logic/cseac_pkg.sv]
package cseac_pkg;

  typedef enum logic [1:0] {
    CSEAC_ADC_IDLE = 2'b00,
    CSEAC_ADC_START = 2'b01,
    CSEAC_ADC_WAIT = 2'b10
  } cseac_adc_state_t;

  typedef enum logic [1:0] {
    CSEAC_CHG_CHARGING = 2'b00,
    CSEAC_CHG_DONE = 2'b01,
    CSEAC_CHG_FAULT = 2'b10,
    CSEAC_CHG_DISABLED = 2'b11
  } cseac_chg_state_t;

  // Comparator and core status levels, all synchronous to the clock.
  typedef struct packed {
    logic batt_above_3v;
    logic drv_supply_ok;
    logic therm_in_rev_range;
    logic rev_discharge_over;
    logic input_above_ok;
    logic input_above_int_ov;
    logic under_pin_ok;
    logic over_pin_tripped;
    logic high_impedance_state;
    logic in_current_reg;
    logic in_voltage_reg;
    logic watchdog_expired;
    logic thermal_shutdown;
    logic battery_overvoltage;
    logic safety_timer_expired;
    logic charge_inhibit;
    logic [1:0] charge_state_code;
    logic [2:0] thermistor_state_code;
  } cseac_sense_t;

  // Output enables of the open-drain indicators; high pulls the pin low.
  typedef struct packed {
    logic power_good_pin_oe;
    logic charge_state_pin_a_oe;
    logic charge_state_pin_b_oe;
  } cseac_pins_t;

endpackage

// [logic/cseac_top.sv]
`timescale 1ns/10ps
`include "cseac_consts.svh"
// Contract
// - Reverse mode runs only with battery above 3 V, supply ok, enable set, temperature ok.
// - Reverse-active status reads 1 while running; host clearing enable ends it.
// - Reverse power is cut back while battery discharge exceeds its limit.
// - One-shot rate clears converter enable when the cycle completes.
// - Disabled channels read last valid result, or zero since reset.
// - Channel disabled mid-conversion finishes, then is skipped from next selection.
// - One-shot with every channel disabled clears converter enable.
// - Done status and flag only in one-shot; continuous reads 0, flag untouched.
// - Conversions ignore faults; enable write 0 halts at once, results kept.
// - Switching to one-shot stops after the current full cycle.
// - Power good needs input window, both threshold pins ok, not high impedance.
// - Power-good pin disabled shows only the third force bit.
// - State pins encode charging, done, fault and disabled per the table.
// - State pins disabled follow force bits; reverse mode keeps both off.
// - Each unmasked event outside an active pulse gives one active-low 256 us alert pulse.
// - Alert sources cover input, regulation, watchdog, state changes, faults, status edges.
// - Each source has live status, latched flag and mask suppressing its pulse.
// - Status rising edge sets flag; host read clears it until next edge.
// - Input overvoltage stops charging, alerts, sets status, drops power good.
// - Input undervoltage stops charging, alerts, sets status, drops power good.
module cseac_top
  import cseac_pkg::*;
#(
  parameter int NCH = 8,
  parameter int RES_W = 16,
  parameter int ALERT_CYCLES = `CSEAC_ALERT_US * `CSEAC_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire cseac_sense_t sense,
  input wire logic adc_data_valid,
  input wire logic [RES_W-1:0] adc_data,
  output logic adc_convert,
  output logic [$clog2(NCH)-1:0] adc_channel,
  output cseac_pins_t pins,
  output logic host_alert_n,
  output logic reverse_active,
  output logic reverse_cutback,
  output logic charger_run
);

  localparam int CW = $clog2(NCH);
  localparam int AW = $clog2(ALERT_CYCLES + 1);
  localparam logic [AW-1:0] ALERT_LOAD = AW'(ALERT_CYCLES - 1);
  localparam int NS = `CSEAC_NSRC;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus decode.

  logic wait_reg;
  logic [31:0] readdata_reg;
  logic [`CSEAC_CTRL_W-1:0] ctrl_reg;
  logic [NCH-1:0] adc_dis_reg;
  logic [NS-1:0] flag_reg;
  logic [NS-1:0] mask_reg;
  logic [NS-1:0] status_w;
  logic [RES_W-1:0] result_mem [NCH];

  wire bus_req = avs_read | avs_write;
  wire bus_fire = bus_req & ~wait_reg;
  wire wr_fire = bus_fire & avs_write;
  wire rd_fire = bus_fire & avs_read;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire sel_ctrl = avs_address == `CSEAC_ADDR_CTRL;
  wire sel_dis = avs_address == `CSEAC_ADDR_ADC_DIS;
  wire sel_status = avs_address == `CSEAC_ADDR_STATUS;
  wire sel_flag = avs_address == `CSEAC_ADDR_FLAG;
  wire sel_mask = avs_address == `CSEAC_ADDR_MASK;
  wire [7:0] res_off = avs_address - `CSEAC_ADDR_RESULT;
  wire sel_res = (avs_address >= `CSEAC_ADDR_RESULT) && (res_off[7:2] < NCH)
                 && (res_off[1:0] == 2'h0);
  wire [CW-1:0] res_idx = res_off[CW+1:2];
  wire [31:0] wr_ctrl = (32'(ctrl_reg) & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] wr_dis = (32'(adc_dis_reg) & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] wr_mask = (32'(mask_reg) & ~be_mask) | (avs_writedata & be_mask);

  // Unmapped addresses read as zero and ignore writes.
  wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_reg) :
                       sel_dis ? 32'(adc_dis_reg) :
                       sel_status ? 32'(status_w) :
                       sel_flag ? 32'(flag_reg) :
                       sel_mask ? 32'(mask_reg) :
                       sel_res ? 32'(result_mem[res_idx]) : 32'h0000_0000;

  // Read data is captured one edge before the answer so that it stands when taken.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg <= 1'b1;
      readdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~wait_reg | ~bus_req;
      if (bus_req && wait_reg) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reverse mode, input protection and power good.

  wire rev_en = ctrl_reg[`CSEAC_CTRL_REV_EN];
  wire rev_ok = rev_en & sense.batt_above_3v & sense.drv_supply_ok
                & sense.therm_in_rev_range;
  wire in_ov = sense.input_above_int_ov | sense.over_pin_tripped;
  wire in_uv = ~sense.input_above_ok | ~sense.under_pin_ok;
  wire pg_ok = ~in_ov & ~in_uv & ~sense.high_impedance_state;
  wire chg_en = ctrl_reg[`CSEAC_CTRL_CHG_EN];
  wire chg_off = ~chg_en | sense.charge_inhibit;
  wire run_next = chg_en & ~sense.charge_inhibit & ~in_ov & ~in_uv;

  logic reverse_active_reg;
  logic reverse_cutback_reg;
  logic charger_run_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reverse_active_reg <= 1'b0;
      reverse_cutback_reg <= 1'b0;
      charger_run_reg <= 1'b0;
    end else begin
      reverse_active_reg <= rev_ok;
      reverse_cutback_reg <= rev_ok & sense.rev_discharge_over;
      charger_run_reg <= run_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indicator pins.

  wire [1:0] chg_code = sense.charge_state_code;
  wire tbl_a = ~chg_off & ((chg_code == CSEAC_CHG_CHARGING) | (chg_code == CSEAC_CHG_FAULT));
  wire tbl_b = ~chg_off & ((chg_code == CSEAC_CHG_DONE) | (chg_code == CSEAC_CHG_FAULT));
  wire state_dis = ctrl_reg[`CSEAC_CTRL_STATE_DIS];
  wire pin_a_next = ~rev_ok & (state_dis ? ctrl_reg[`CSEAC_CTRL_FORCE_A] : tbl_a);
  wire pin_b_next = ~rev_ok & (state_dis ? ctrl_reg[`CSEAC_CTRL_FORCE_B] : tbl_b);
  wire pg_pin_next = ctrl_reg[`CSEAC_CTRL_PG_DIS] ? ctrl_reg[`CSEAC_CTRL_FORCE_C] : pg_ok;

  cseac_pins_t pins_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pins_reg <= '0;
    end else begin
      pins_reg.power_good_pin_oe <= pg_pin_next;
      pins_reg.charge_state_pin_a_oe <= pin_a_next;
      pins_reg.charge_state_pin_b_oe <= pin_b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Converter sequencer.

  cseac_adc_state_t adc_state_reg;
  cseac_adc_state_t adc_state_next;
  logic [CW-1:0] chan_reg;
  logic convert_reg;
  logic done_reg;

  wire adc_en = ctrl_reg[`CSEAC_CTRL_ADC_EN];
  wire oneshot = ctrl_reg[`CSEAC_CTRL_ONESHOT];
  wire [NCH-1:0] chan_on = ~adc_dis_reg;

  // Lowest enabled channel at or above a starting index.
  function automatic logic [CW:0] cseac_pick(input logic [NCH-1:0] on, input int from);
    logic [CW:0] res;
    res = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (on[i] && i >= from) begin
        res = {1'b1, CW'(i)};
      end
    end
    return res;
  endfunction

  // Disable bits are only sampled at selection, so a running conversion completes.
  wire [CW:0] first_pick = cseac_pick(chan_on, 0);
  wire [CW:0] next_pick = cseac_pick(chan_on, int'(chan_reg) + 1);
  wire idle_none = adc_state_reg == CSEAC_ADC_IDLE && adc_en && !first_pick[CW];
  wire got_data = adc_state_reg == CSEAC_ADC_WAIT && adc_data_valid;
  wire cycle_end = got_data && !next_pick[CW];
  // The rate is checked only at the end of a full cycle, or in idle with no channel enabled.
  wire hw_clear_en = (cycle_end && oneshot) || (idle_none && oneshot);
  wire host_en_write = wr_fire && sel_ctrl && avs_byteenable[0];

  always_comb begin
    adc_state_next = adc_state_reg;
    case (adc_state_reg)
      CSEAC_ADC_IDLE: begin
        if (adc_en && first_pick[CW]) begin
          adc_state_next = CSEAC_ADC_START;
        end
      end
      CSEAC_ADC_START: begin
        adc_state_next = CSEAC_ADC_WAIT;
      end
      CSEAC_ADC_WAIT: begin
        if (adc_data_valid) begin
          adc_state_next = (next_pick[CW] || !oneshot) ? CSEAC_ADC_START : CSEAC_ADC_IDLE;
        end
      end
      default: begin
        adc_state_next = CSEAC_ADC_IDLE;
      end
    endcase
    if (cycle_end && !oneshot && !first_pick[CW]) begin
      adc_state_next = CSEAC_ADC_IDLE;
    end
    if (!adc_en) begin
      adc_state_next = CSEAC_ADC_IDLE;
    end
  end

  wire [CW-1:0] chan_next = (adc_state_reg == CSEAC_ADC_IDLE) ? first_pick[CW-1:0] :
                            next_pick[CW] ? next_pick[CW-1:0] : first_pick[CW-1:0];
  wire load_chan = (adc_state_reg == CSEAC_ADC_IDLE && adc_state_next == CSEAC_ADC_START)
                   || got_data;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      adc_state_reg <= CSEAC_ADC_IDLE;
      chan_reg <= '0;
      convert_reg <= 1'b0;
    end else begin
      adc_state_reg <= adc_state_next;
      convert_reg <= adc_state_next == CSEAC_ADC_START;
      if (load_chan) begin
        chan_reg <= chan_next;
      end
    end
  end

  // Results survive disabling and halting; only a finished conversion updates one.
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_res
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          result_mem[g] <= '0;
        end else if (got_data && adc_en && chan_reg == CW'(g)) begin
          result_mem[g] <= adc_data;
        end
      end
    end
  endgenerate

  // Done is meaningful only in one-shot rate; continuous rate forces it to zero.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_reg <= 1'b0;
    end else if (!oneshot || host_en_write) begin
      done_reg <= 1'b0;
    end else if (cycle_end && adc_en) begin
      done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // A host write of the enable takes priority over the hardware clear in the same cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `CSEAC_CTRL_RESET;
      adc_dis_reg <= '0;
      mask_reg <= `CSEAC_MASK_RESET;
    end else begin
      if (wr_fire && sel_ctrl) begin
        ctrl_reg <= wr_ctrl[`CSEAC_CTRL_W-1:0];
      end else if (hw_clear_en) begin
        ctrl_reg[`CSEAC_CTRL_ADC_EN] <= 1'b0;
      end
      if (wr_fire && sel_dis) begin
        adc_dis_reg <= wr_dis[NCH-1:0];
      end
      if (wr_fire && sel_mask) begin
        mask_reg <= wr_mask[NS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, flags and alert pulse.

  logic [NS-1:0] status_prev_reg;
  logic [1:0] chg_prev_reg;
  logic [2:0] ts_prev_reg;
  logic [AW-1:0] alert_cnt_reg;
  logic alert_n_reg;

  assign status_w[`CSEAC_ST_PG] = pg_ok;
  assign status_w[`CSEAC_ST_IN_CUR_REG] = sense.in_current_reg;
  assign status_w[`CSEAC_ST_IN_VOLT_REG] = sense.in_voltage_reg;
  assign status_w[`CSEAC_ST_WATCHDOG] = sense.watchdog_expired;
  assign status_w[`CSEAC_ST_CHG_CHANGE] = chg_code != chg_prev_reg;
  assign status_w[`CSEAC_ST_TS_CHANGE] = sense.thermistor_state_code != ts_prev_reg;
  assign status_w[`CSEAC_ST_THERMAL_SHUTDOWN] = sense.thermal_shutdown;
  assign status_w[`CSEAC_ST_BAT_OV] = sense.battery_overvoltage;
  assign status_w[`CSEAC_ST_SAFETY] = sense.safety_timer_expired;
  assign status_w[`CSEAC_ST_IN_OV] = in_ov;
  assign status_w[`CSEAC_ST_IN_UV] = in_uv;
  assign status_w[`CSEAC_ST_REVERSE] = reverse_active_reg;
  assign status_w[`CSEAC_ST_ADC_DONE] = done_reg;

  // Power good losing validity is an event as well as gaining it.
  wire [NS-1:0] pg_fall = NS'(~pg_ok & status_prev_reg[`CSEAC_ST_PG]) << `CSEAC_ST_PG;
  wire [NS-1:0] events = (status_w & ~status_prev_reg) | pg_fall;
  wire [NS-1:0] flag_clr = (rd_fire && sel_flag) ? readdata_reg[NS-1:0] : {NS{1'b0}};
  wire alert_req = |(events & ~mask_reg);
  wire alert_start = alert_req && alert_n_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_prev_reg <= '0;
      chg_prev_reg <= 2'h0;
      ts_prev_reg <= 3'h0;
      flag_reg <= '0;
    end else begin
      status_prev_reg <= status_w;
      chg_prev_reg <= chg_code;
      ts_prev_reg <= sense.thermistor_state_code;
      // Only flags the host has seen are cleared, so an edge during the read survives it.
      flag_reg <= (flag_reg & ~flag_clr) | events;
    end
  end

  // Events during an active pulse are not queued; their flags still record them.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alert_cnt_reg <= '0;
      alert_n_reg <= 1'b1;
    end else if (alert_start) begin
      alert_cnt_reg <= ALERT_LOAD;
      alert_n_reg <= 1'b0;
    end else if (!alert_n_reg) begin
      if (alert_cnt_reg == '0) begin
        alert_n_reg <= 1'b1;
      end else begin
        alert_cnt_reg <= alert_cnt_reg - AW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign adc_convert = convert_reg;
  assign adc_channel = chan_reg;
  assign pins = pins_reg;
  assign host_alert_n = alert_n_reg;
  assign reverse_active = reverse_active_reg;
  assign reverse_cutback = reverse_cutback_reg;
  assign charger_run = charger_run_reg;

endmodule
